// ### core/sfr_filter.sv
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module sfr_filter #(
  parameter int DW = 24
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic bitstream_in,
  input wire logic [2:0] channel_in,
  output logic modulator_reset_out,
  output logic [DW-1:0] result_out,
  output logic result_valid_out,
  output logic result_settled_out,
  output logic third_order_out,
  output logic notch_active_out
);
  typedef struct packed {
    logic [9:0] filter_word;
    logic notch;
    logic zero_latency;
    logic third_order;
    logic notch_active;
    logic [9:0] sub;
    logic [9:0] dec;
    logic [2:0] periods;
    sfr_pkg::sfr_state_t state;
    logic [DW-1:0] acc;
    logic [DW-1:0] result;
    logic valid;
    logic settled;
    logic mod_reset;
    logic [2:0] chan;
    logic [31:0] count;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic bs1;
    logic bs2;
    logic [2:0] ch1;
    logic [2:0] ch2;
  } sfr_regs_t;

  // Power-up state: fourth order, zero latency off, default filter word
  localparam sfr_regs_t RESET_R = '{
    filter_word: sfr_pkg::FW_RESET,
    notch: 1'b0,
    zero_latency: 1'b0,
    third_order: 1'b0,
    notch_active: 1'b0,
    sub: 10'h0,
    dec: 10'h0,
    periods: 3'h0,
    state: sfr_pkg::ST_SETTLE,
    acc: '0,
    result: '0,
    valid: 1'b0,
    settled: 1'b0,
    mod_reset: 1'b0,
    chan: 3'h0,
    count: 32'h0,
    prdata: 32'h0,
    pready: 1'b0,
    pslverr: 1'b0,
    bs1: 1'b0,
    bs2: 1'b0,
    ch1: 3'h0,
    ch2: 3'h0
  };

  sfr_regs_t r;
  sfr_regs_t next_r;
  // Bus decode
  logic access;
  logic wr_mode;
  logic wr_ctrl;
  logic rd_err;
  logic chan_moved;
  logic restart;
  logic [9:0] fw_wr;
  logic [9:0] fw_next;
  logic notch_next;

  // Conversion timing
  logic counting;
  logic settle_phase;
  logic last_sub;
  logic last_dec;
  logic period_end;
  logic settle_done;
  logic [2:0] settle_len;
  logic [9:0] sub_inc;
  logic [9:0] dec_inc;
  logic [2:0] periods_inc;
  logic [31:0] count_inc;
  logic [DW-1:0] acc_sum;

  // Settling time in output data periods for the selected order
  function automatic logic [2:0] settle_periods(input logic third);
    if (third) begin
      settle_periods = sfr_pkg::SETTLE_THIRD_ORDER_SELECT;
    end else begin
      settle_periods = sfr_pkg::SETTLE_SINC4;
    end
  endfunction

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
    addr_is = (a == target);
  endfunction

  function automatic logic flag_of(input logic [31:0] d, input int pos);
    flag_of = d[pos];
  endfunction

  function automatic logic [31:0] mode_word(input sfr_regs_t s);
    mode_word = 32'h0;
    mode_word[sfr_pkg::FW_LSB +: sfr_pkg::FW_W] = s.filter_word;
    mode_word[sfr_pkg::NOTCH_BIT] = s.notch;
    mode_word[sfr_pkg::ZL_BIT] = s.zero_latency;
    mode_word[sfr_pkg::ORDER_BIT] = s.third_order;
    // Chop is not offered; its bit always reads zero
    mode_word[sfr_pkg::CHOP_BIT] = 1'b0;
  endfunction

  function automatic logic [31:0] status_word(input sfr_regs_t s);
    status_word = {26'h0, s.chan, s.settled, s.state};
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] a, input sfr_regs_t s);
    unique case (a)
      sfr_pkg::ADDR_MODE: begin
        read_word = mode_word(s);
      end
      sfr_pkg::ADDR_CTRL: begin
        read_word = 32'h0;
      end
      sfr_pkg::ADDR_STATUS: begin
        read_word = status_word(s);
      end
      sfr_pkg::ADDR_DATA: begin
        read_word = 32'(s.result);
      end
      sfr_pkg::ADDR_COUNT: begin
        read_word = s.count;
      end
      default: begin
        read_word = 32'h0;
      end
    endcase
  endfunction

  // Unmapped offsets answer with an error and zero data
  function automatic logic unmapped(input logic [7:0] a);
    unique case (a)
      sfr_pkg::ADDR_MODE: begin
        unmapped = 1'b0;
      end
      sfr_pkg::ADDR_CTRL: begin
        unmapped = 1'b0;
      end
      sfr_pkg::ADDR_STATUS: begin
        unmapped = 1'b0;
      end
      sfr_pkg::ADDR_DATA: begin
        unmapped = 1'b0;
      end
      sfr_pkg::ADDR_COUNT: begin
        unmapped = 1'b0;
      end
      default: begin
        unmapped = 1'b1;
      end
    endcase
  endfunction

  function automatic logic notch_hit(input logic notch, input logic [9:0] fw);
    notch_hit = notch && (fw == sfr_pkg::FW_NOTCH);
  endfunction

  // One wait state: the access phase counts once, while the answer is not yet out
  assign access = psel_in && penable_in && !r.pready;
  assign wr_mode = access && pwrite_in && addr_is(paddr_in, sfr_pkg::ADDR_MODE);
  assign wr_ctrl = access && pwrite_in && addr_is(paddr_in, sfr_pkg::ADDR_CTRL) && flag_of(pwdata_in, 0);
  assign rd_err = unmapped(paddr_in);
  // A new channel restarts the modulator and the filter
  assign chan_moved = (r.ch2 != r.chan);
  assign restart = wr_mode || wr_ctrl || chan_moved;
  assign fw_wr = pwdata_in[sfr_pkg::FW_LSB +: sfr_pkg::FW_W];
  assign fw_next = wr_mode ? fw_wr : r.filter_word;
  assign notch_next = wr_mode ? flag_of(pwdata_in, sfr_pkg::NOTCH_BIT) : r.notch;

  // sub counts modulator clocks, dec counts blocks of 1024 up to filter_word
  assign counting = (r.state == sfr_pkg::ST_SETTLE) || (r.state == sfr_pkg::ST_RUN);
  assign settle_phase = (r.state == sfr_pkg::ST_SETTLE) || r.zero_latency;
  assign last_sub = (r.sub == 10'(sfr_pkg::DEC_BASE - 1));
  assign last_dec = (r.dec == r.filter_word - 10'h1);
  assign period_end = counting && last_sub && last_dec;
  // periods counts completed output data periods of the settling phase
  assign settle_len = settle_periods(r.third_order);
  assign settle_done = (r.periods == settle_len - 3'h1);
  assign sub_inc = r.sub + 10'h1;
  assign dec_inc = r.dec + 10'h1;
  assign periods_inc = r.periods + 3'h1;
  assign count_inc = r.count + 32'h1;
  // The bit of the closing cycle still belongs to the closing conversion
  assign acc_sum = r.acc + DW'(r.bs2);

  always_comb begin
    next_r = r;
    // Pins from the modulator side pass two flops before any logic reads them
    next_r.bs1 = bitstream_in;
    next_r.bs2 = r.bs1;
    next_r.ch1 = channel_in;
    next_r.ch2 = r.ch1;
    next_r.valid = 1'b0;
    next_r.mod_reset = restart;
    next_r.pready = access;
    next_r.pslverr = 1'b0;

    if (access) begin
      next_r.prdata = read_word(paddr_in, r);
      next_r.pslverr = rd_err;
    end

    if (wr_mode) begin
      next_r.filter_word = fw_wr;
      next_r.notch = notch_next;
      next_r.zero_latency = flag_of(pwdata_in, sfr_pkg::ZL_BIT);
      next_r.third_order = flag_of(pwdata_in, sfr_pkg::ORDER_BIT);
    end
    next_r.notch_active = notch_hit(notch_next, fw_next);

    if (chan_moved) begin
      next_r.chan = r.ch2;
    end

    if (restart) begin
      // Modulator and filter start over; the next result waits a full settling time
      next_r.sub = 10'h0;
      next_r.dec = 10'h0;
      next_r.periods = 3'h0;
      next_r.acc = '0;
      next_r.settled = 1'b0;
      // A zero filter word parks the converter until the next restart
      if (fw_next == 10'h0) begin
        next_r.state = sfr_pkg::ST_IDLE;
      end else begin
        next_r.state = sfr_pkg::ST_SETTLE;
      end
    end else begin
      unique case (r.state)
        sfr_pkg::ST_IDLE: begin
          next_r.state = sfr_pkg::ST_IDLE;
        end

        sfr_pkg::ST_SETTLE, sfr_pkg::ST_RUN: begin
          next_r.acc = acc_sum;

          if (last_sub) begin
            next_r.sub = 10'h0;
          end else begin
            next_r.sub = sub_inc;
          end

          if (last_sub && last_dec) begin
            next_r.dec = 10'h0;
          end else if (last_sub) begin
            next_r.dec = dec_inc;
          end

          if (period_end) begin
            if (settle_phase) begin
              // Settling phase, or zero latency: a result only after a full settling time
              if (settle_done) begin
                next_r.periods = 3'h0;
                next_r.valid = 1'b1;
                next_r.state = sfr_pkg::ST_RUN;
              end else begin
                next_r.periods = periods_inc;
              end
            end else begin
              // Settled: one result per period, a step shows three (third order) or four (fourth order) results later
              next_r.valid = 1'b1;
            end
          end

          if (next_r.valid) begin
            next_r.result = acc_sum;
            next_r.acc = '0;
            next_r.count = count_inc;
            // Results since the last restart are all settled ones
            next_r.settled = 1'b1;
          end
        end

        default: begin
          next_r.state = sfr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= RESET_R;
    end else begin
      r <= next_r;
    end
  end

  // Every output is a flop of the state register
  assign prdata_out = r.prdata;
  assign pready_out = r.pready;
  assign pslverr_out = r.pslverr;
  assign modulator_reset_out = r.mod_reset;
  assign result_out = r.result;
  assign result_valid_out = r.valid;
  assign result_settled_out = r.settled;
  assign third_order_out = r.third_order;
  assign notch_active_out = r.notch_active;
endmodule
`default_nettype wire

// ### core/sfr_pkg.sv
package sfr_pkg;
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0c;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam int FW_LSB = 0;
  localparam int FW_W = 10;
  localparam int NOTCH_BIT = 10;
  localparam int ZL_BIT = 11;
  localparam int ORDER_BIT = 12;
  localparam int CHOP_BIT = 13;
  localparam logic [9:0] FW_RESET = 10'h060;
  localparam logic [9:0] FW_NOTCH = 10'h060;
  localparam int DEC_BASE = 1024;
  localparam logic [2:0] SETTLE_SINC4 = 3'h4;
  localparam logic [2:0] SETTLE_THIRD_ORDER_SELECT = 3'h3;
  localparam int NOTCH_SPAN = 5;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_RUN
  } sfr_state_t;
endpackage

// ### sim/sfr_filter_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sfr_filter_asserts (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic modulator_reset_out,
  input wire logic result_valid_out,
  input wire logic third_order_out,
  input wire logic notch_active_out
);
  wire mw = psel_in && penable_in && pwrite_in && paddr_in == sfr_pkg::ADDR_MODE;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  property p_vld; result_valid_out |=> !result_valid_out; endproperty
  a_vld: assert property (p_vld) else $error("valid too long");
  property p_rdy; pready_out |=> !pready_out; endproperty
  a_rdy: assert property (p_rdy) else $error("ready too long");
  property p_err; pslverr_out |-> pready_out; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_ord; mw && pready_out |=> third_order_out == $past(pwdata_in[12]); endproperty
  a_ord: assert property (p_ord) else $error("order select wrong");
  property p_nch; mw && pready_out |=> notch_active_out == ($past(pwdata_in[10])
    && $past(pwdata_in[9:0]) == sfr_pkg::FW_NOTCH); endproperty
  a_nch: assert property (p_nch) else $error("notch flag wrong");
  property p_rst; mw && !pready_out |-> ##[0:3] modulator_reset_out; endproperty
  a_rst: assert property (p_rst) else $error("no restart");
  property p_gap; modulator_reset_out |=> !result_valid_out [*8]; endproperty
  a_gap: assert property (p_gap) else $error("result right after restart");
  property p_def; $rose(reset_n_in) |-> !third_order_out && !notch_active_out; endproperty
  a_def: assert property (p_def) else $error("reset config wrong");
endmodule
bind sfr_filter sfr_filter_asserts i_chk(.*);
`default_nettype wire

// ### sim/sfr_mod_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfr_mod_model(
  input wire logic mclk_in,
  input wire logic reset_n_in,
  output logic bit_out
);
  // Bitstream only: this side never asks for a calibration
  // Density one half: any even window holds exactly half ones
  always_ff @(posedge mclk_in or negedge reset_n_in)
    if (!reset_n_in) bit_out <= 1'b0;
    else bit_out <= !bit_out;
endmodule
`default_nettype wire

// ### sim/tb_sinc_filter_rate_settling.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sinc_filter_rate_settling;
  logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, bs, rdy, perr, mrst, vld, ord, nch, err, sett;
  logic [7:0] pa = 0;
  logic [31:0] pwd = 0, rd, prd;
  logic [2:0] ch = 0;
  logic [23:0] res;
  int mismatches = 0, samples_checked = 0, cyc = 0, n;
  sfr_filter i_dut(.mclk_in(clk), .reset_n_in(rstn), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
    .pslverr_out(perr), .bitstream_in(bs), .channel_in(ch), .modulator_reset_out(mrst),
    .result_out(res), .result_valid_out(vld), .result_settled_out(sett), .third_order_out(ord),
    .notch_active_out(nch));
  sfr_mod_model i_mod(.mclk_in(clk), .reset_n_in(rstn), .bit_out(bs));
  initial forever #50 clk = ~clk;
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = prd;
    err = perr;
    {psel, pen} <= 2'b00;
  endtask
  // Cycles to next result, within tolerance of the expected figure
  task wv(input int e, input int tol);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (vld !== 1'b1);
    chk(32'(n >= e - tol && n <= e + tol), 32'h1);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      finish_test;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    apb(0, sfr_pkg::ADDR_MODE, 0);
    chk(rd, 32'h60);
    apb(0, 8'h40, 0);
    chk(32'(err), 32'h1);
    apb(1, sfr_pkg::ADDR_MODE, 32'h1);
    chk(32'(sett), 32'h0);
    wv(4096, 8);
    wv(1024, 0);
    chk(32'(res), 32'h200);
    chk(32'(sett), 32'h1);
    apb(1, sfr_pkg::ADDR_MODE, 32'h1001);
    chk(32'(ord), 32'h1);
    wv(3072, 8);
    wv(1024, 0);
    ch <= 3'h5;
    wv(3072, 8);
    wv(1024, 0);
    apb(1, sfr_pkg::ADDR_MODE, 32'h801);
    wv(4096, 8);
    wv(4096, 0);
    apb(0, sfr_pkg::ADDR_DATA, 0);
    chk(rd, 32'h800);
    apb(1, sfr_pkg::ADDR_MODE, 32'h1801);
    wv(3072, 8);
    wv(3072, 0);
    apb(1, sfr_pkg::ADDR_CTRL, 32'h1);
    wv(3072, 0);
    apb(1, sfr_pkg::ADDR_MODE, 32'h460);
    chk(32'(nch), 32'h1);
    apb(1, sfr_pkg::ADDR_MODE, 32'h401);
    chk(32'(nch), 32'h0);
    $display("rate tests done");
    finish_test;
  end
endmodule
`default_nettype wire
